// ---- gpio_cfg_pkg.sv ----
package gpio_cfg_pkg;

    localparam int          ADDR_W         = 32;
    localparam int          DATA_W         = 32;
    localparam int          PIN_CNT        = 16;
    localparam int          STRB_W         = DATA_W / 8;

    // register byte addresses
    localparam logic [31:0] PIN_ENABLE_ADDR  = 32'h01B0_0000;
    localparam logic [31:0] PIN_DIR_ADDR     = 32'h01B0_0004;
    localparam logic [31:0] PIN_DOUT_ADDR    = 32'h01B0_0008;
    localparam logic [31:0] PIN_STATE_ADDR   = 32'h01B0_000C;
    localparam logic [31:0] WORD_MASK        = 32'hFFFF_FFFC;

    // field layout and reset values
    localparam logic [31:0] PIN_FIELD_MASK   = 32'h0000_FFFF;
    localparam logic [15:0] ENABLE_RESET     = 16'h00F9;
    localparam logic [15:0] DIR_RESET        = 16'h0000;
    localparam logic [15:0] DOUT_RESET       = 16'h0000;
    localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

    // direction bit encoding
    localparam logic        DIR_INPUT        = 1'h0;
    localparam logic        DIR_OUTPUT       = 1'h1;

    // axi response codes
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_DECERR      = 2'h3;

    typedef enum logic [4:0] {
        SEL_ENABLE = 5'h01,
        SEL_DIR    = 5'h02,
        SEL_DOUT   = 5'h04,
        SEL_STATE  = 5'h08,
        SEL_NONE   = 5'h10
    } reg_sel_t;

    typedef enum logic [4:0] {
        W_IDLE     = 5'h01,
        W_HAVE_A   = 5'h02,
        W_HAVE_D   = 5'h04,
        W_COMMIT   = 5'h08,
        W_RESP     = 5'h10
    } wr_state_t;

    typedef enum logic [2:0] {
        R_IDLE     = 3'h1,
        R_FETCH    = 3'h2,
        R_RESP     = 3'h4
    } rd_state_t;

endpackage : gpio_cfg_pkg

// ---- pin_cfg_if.sv ----
`timescale 1ns/10ps
interface pin_cfg_if;
    import gpio_cfg_pkg::*;

    logic [PIN_CNT-1:0] enable;
    logic [PIN_CNT-1:0] dir;
    logic [PIN_CNT-1:0] dout;
    logic [PIN_CNT-1:0] sampled;

    modport ctrl (
        output enable,
        output dir,
        output dout,
        input  sampled
    );

    modport pins (
        input  enable,
        input  dir,
        input  dout,
        output sampled
    );

endinterface : pin_cfg_if

// ---- gpio_pin_mux.sv ----
`timescale 1ns/10ps
module gpio_pin_mux
    import gpio_cfg_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    pin_cfg_if.pins                 cfg,
    input  wire logic [PIN_CNT-1:0] pin_in,
    input  wire logic [PIN_CNT-1:0] alt_out_in,
    input  wire logic [PIN_CNT-1:0] alt_oe_n_in,
    output logic      [PIN_CNT-1:0] pin_out_q,
    output logic      [PIN_CNT-1:0] pin_oe_n_q
);

    logic [PIN_CNT-1:0] pin_out_d;
    logic [PIN_CNT-1:0] pin_oe_n_d;
    logic [PIN_CNT-1:0] sampled_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < PIN_CNT; i++) begin
            if (cfg.enable[i]) begin
                // direction only matters once the pin is ours
                pin_out_d[i]  = cfg.dout[i];
                pin_oe_n_d[i] = (cfg.dir[i] != DIR_OUTPUT);
            end else begin
                // alternate function drives the pad from alt_out_in and alt_oe_n_in
                pin_out_d[i]  = alt_out_in[i];
                pin_oe_n_d[i] = alt_oe_n_in[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_out_q  <= '0;
            pin_oe_n_q <= '1;
        end else begin
            pin_out_q  <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sampled_q <= '0;
        end else begin
            sampled_q <= pin_in;
        end
    end

    assign cfg.sampled = sampled_q;

endmodule : gpio_pin_mux

// ---- gpio_pin_enable_direction.sv ----
`timescale 1ns/10ps
module gpio_pin_enable_direction
    import gpio_cfg_pkg::*;
(
    input  wire logic                CORE_CLK_IN,
    input  wire logic                RST_N_IN,
    input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR_IN,
    input  wire logic                S_AXI_AWVALID_IN,
    output logic                     S_AXI_AWREADY_OUT,
    input  wire logic [DATA_W-1:0]   S_AXI_WDATA_IN,
    input  wire logic [STRB_W-1:0]   S_AXI_WSTRB_IN,
    input  wire logic                S_AXI_WVALID_IN,
    output logic                     S_AXI_WREADY_OUT,
    output logic [1:0]               S_AXI_BRESP_OUT,
    output logic                     S_AXI_BVALID_OUT,
    input  wire logic                S_AXI_BREADY_IN,
    input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR_IN,
    input  wire logic                S_AXI_ARVALID_IN,
    output logic                     S_AXI_ARREADY_OUT,
    output logic [DATA_W-1:0]        S_AXI_RDATA_OUT,
    output logic [1:0]               S_AXI_RRESP_OUT,
    output logic                     S_AXI_RVALID_OUT,
    input  wire logic                S_AXI_RREADY_IN,
    input  wire logic [PIN_CNT-1:0]  GP_PIN_IN,
    input  wire logic [PIN_CNT-1:0]  ALT_OUT_IN,
    input  wire logic [PIN_CNT-1:0]  ALT_OE_N_IN,
    output logic      [PIN_CNT-1:0]  GP_PIN_OUT,
    output logic      [PIN_CNT-1:0]  GP_PIN_OE_N_OUT,
    output logic      [PIN_CNT-1:0]  GPIO_OWNS_PIN_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = addr & WORD_MASK;
        if (word == PIN_ENABLE_ADDR) begin
            decode_addr = SEL_ENABLE;
        end else if (word == PIN_DIR_ADDR) begin
            decode_addr = SEL_DIR;
        end else if (word == PIN_DOUT_ADDR) begin
            decode_addr = SEL_DOUT;
        end else if (word == PIN_STATE_ADDR) begin
            decode_addr = SEL_STATE;
        end else begin
            decode_addr = SEL_NONE;
        end
    endfunction : decode_addr

    // merge write data under byte strobes, upper half always dropped
    function automatic logic [PIN_CNT-1:0] merge_pins(
        input logic [PIN_CNT-1:0] old_val,
        input logic [DATA_W-1:0]  wdata,
        input logic [STRB_W-1:0]  strb
    );
        logic [DATA_W-1:0] merged;
        merged = {{(DATA_W-PIN_CNT){1'b0}}, old_val};
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                merged[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        merged     = merged & PIN_FIELD_MASK;
        merge_pins = merged[PIN_CNT-1:0];
    endfunction : merge_pins

    function automatic logic [DATA_W-1:0] widen(input logic [PIN_CNT-1:0] v);
        widen = {{(DATA_W-PIN_CNT){1'b0}}, v};
    endfunction : widen

    ////////////////////////////////////////////////////////////////////////
    // storage

    pin_cfg_if          cfg_bus();

    wr_state_t          wr_state_q;
    wr_state_t          wr_state_d;
    rd_state_t          rd_state_q;
    rd_state_t          rd_state_d;

    logic [ADDR_W-1:0]  awaddr_q;
    logic [DATA_W-1:0]  wdata_q;
    logic [STRB_W-1:0]  wstrb_q;
    logic [ADDR_W-1:0]  araddr_q;

    logic [PIN_CNT-1:0] enable_q;
    logic [PIN_CNT-1:0] dir_q;
    logic [PIN_CNT-1:0] dout_q;

    logic               awready_q;
    logic               wready_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic               arready_q;
    logic               rvalid_q;
    logic [1:0]         rresp_q;
    logic [DATA_W-1:0]  rdata_q;
    logic [PIN_CNT-1:0] owns_q;

    logic               aw_take;
    logic               w_take;
    reg_sel_t           wr_sel;
    reg_sel_t           rd_sel;

    assign aw_take = S_AXI_AWVALID_IN && awready_q;
    assign w_take  = S_AXI_WVALID_IN && wready_q;
    assign wr_sel  = decode_addr(awaddr_q);
    assign rd_sel  = decode_addr(araddr_q);

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data accepted in either order

    always_comb begin
        wr_state_d = wr_state_q;
        case (wr_state_q)
            W_IDLE: begin
                if (aw_take && w_take) begin
                    wr_state_d = W_COMMIT;
                end else if (aw_take) begin
                    wr_state_d = W_HAVE_A;
                end else if (w_take) begin
                    wr_state_d = W_HAVE_D;
                end
            end
            W_HAVE_A: begin
                if (w_take) begin
                    wr_state_d = W_COMMIT;
                end
            end
            W_HAVE_D: begin
                if (aw_take) begin
                    wr_state_d = W_COMMIT;
                end
            end
            W_COMMIT: begin
                wr_state_d = W_RESP;
            end
            W_RESP: begin
                if (S_AXI_BREADY_IN) begin
                    wr_state_d = W_IDLE;
                end
            end
            default: begin
                wr_state_d = W_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wr_state_q <= W_IDLE;
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
        end else begin
            wr_state_q <= wr_state_d;
            awready_q  <= (wr_state_d == W_IDLE) || (wr_state_d == W_HAVE_D);
            wready_q   <= (wr_state_d == W_IDLE) || (wr_state_d == W_HAVE_A);
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            awaddr_q <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else begin
            if (aw_take) begin
                awaddr_q <= S_AXI_AWADDR_IN;
            end
            if (w_take) begin
                wdata_q <= S_AXI_WDATA_IN;
                wstrb_q <= S_AXI_WSTRB_IN;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_state_q == W_COMMIT) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (bvalid_q && S_AXI_BREADY_IN) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; pin state register is read-only

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            enable_q <= ENABLE_RESET;
            dir_q    <= DIR_RESET;
            dout_q   <= DOUT_RESET;
        end else if (wr_state_q == W_COMMIT) begin
            case (wr_sel)
                SEL_ENABLE: begin
                    enable_q <= merge_pins(enable_q, wdata_q, wstrb_q);
                end
                SEL_DIR: begin
                    dir_q <= merge_pins(dir_q, wdata_q, wstrb_q);
                end
                SEL_DOUT: begin
                    dout_q <= merge_pins(dout_q, wdata_q, wstrb_q);
                end
                default: begin
                    dout_q <= dout_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel

    always_comb begin
        rd_state_d = rd_state_q;
        case (rd_state_q)
            R_IDLE: begin
                if (S_AXI_ARVALID_IN && arready_q) begin
                    rd_state_d = R_FETCH;
                end
            end
            R_FETCH: begin
                rd_state_d = R_RESP;
            end
            R_RESP: begin
                if (S_AXI_RREADY_IN) begin
                    rd_state_d = R_IDLE;
                end
            end
            default: begin
                rd_state_d = R_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_state_q <= R_IDLE;
            arready_q  <= 1'b1;
            araddr_q   <= '0;
        end else begin
            rd_state_q <= rd_state_d;
            arready_q  <= (rd_state_d == R_IDLE);
            if (S_AXI_ARVALID_IN && arready_q) begin
                araddr_q <= S_AXI_ARADDR_IN;
            end
        end
    end

    // data is sampled one cycle after the address so decode stays off
    // the ready path, at the cost of one extra cycle of read latency
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= READ_ZERO;
        end else if (rd_state_q == R_FETCH) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            case (rd_sel)
                SEL_ENABLE: rdata_q <= widen(enable_q);
                SEL_DIR:    rdata_q <= widen(dir_q);
                SEL_DOUT:   rdata_q <= widen(dout_q);
                SEL_STATE:  rdata_q <= widen(cfg_bus.sampled);
                default: begin
                    rdata_q <= READ_ZERO;
                    rresp_q <= RESP_DECERR;
                end
            endcase
        end else if (rvalid_q && S_AXI_RREADY_IN) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin control

    assign cfg_bus.enable = enable_q;
    assign cfg_bus.dir    = dir_q;
    assign cfg_bus.dout   = dout_q;

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            owns_q <= ENABLE_RESET;
        end else begin
            owns_q <= enable_q;
        end
    end

    gpio_pin_mux u_pin_mux (
        .clk_in      (CORE_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .cfg         (cfg_bus.pins),
        .pin_in      (GP_PIN_IN),
        .alt_out_in  (ALT_OUT_IN),
        .alt_oe_n_in (ALT_OE_N_IN),
        .pin_out_q   (GP_PIN_OUT),
        .pin_oe_n_q  (GP_PIN_OE_N_OUT)
    );

    assign S_AXI_AWREADY_OUT = awready_q;
    assign S_AXI_WREADY_OUT  = wready_q;
    assign S_AXI_BVALID_OUT  = bvalid_q;
    assign S_AXI_BRESP_OUT   = bresp_q;
    assign S_AXI_ARREADY_OUT = arready_q;
    assign S_AXI_RVALID_OUT  = rvalid_q;
    assign S_AXI_RRESP_OUT   = rresp_q;
    assign S_AXI_RDATA_OUT   = rdata_q;
    assign GPIO_OWNS_PIN_OUT = owns_q;

endmodule : gpio_pin_enable_direction

// ---- gpio_pin_enable_direction_assertions.sv ----
`timescale 1ns/10ps
module gpio_pin_enable_direction_assertions
    import gpio_cfg_pkg::*;
(
    input wire logic              CORE_CLK_IN,
    input wire logic              RST_N_IN,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic              S_AXI_AWVALID_IN,
    input wire logic              S_AXI_AWREADY_OUT,
    input wire logic [DATA_W-1:0] S_AXI_WDATA_IN,
    input wire logic [STRB_W-1:0] S_AXI_WSTRB_IN,
    input wire logic              S_AXI_WVALID_IN,
    input wire logic              S_AXI_WREADY_OUT,
    input wire logic [1:0]        S_AXI_BRESP_OUT,
    input wire logic              S_AXI_BVALID_OUT,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic              S_AXI_ARVALID_IN,
    input wire logic              S_AXI_ARREADY_OUT,
    input wire logic [DATA_W-1:0] S_AXI_RDATA_OUT,
    input wire logic [1:0]        S_AXI_RRESP_OUT,
    input wire logic              S_AXI_RVALID_OUT,
    input wire logic [15:0]       ALT_OUT_IN,
    input wire logic [15:0]       ALT_OE_N_IN,
    input wire logic [15:0]       GP_PIN_OUT,
    input wire logic [15:0]       GP_PIN_OE_N_OUT,
    input wire logic [15:0]       GPIO_OWNS_PIN_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    logic        wr_take;
    logic        rd_take;
    logic [31:0] aw_word;
    logic [31:0] ar_word;
    logic [15:0] en_exp_q;
    assign wr_take = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
                     && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
    assign rd_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    assign aw_word = S_AXI_AWADDR_IN & 32'hFFFF_FFFC;
    assign ar_word = S_AXI_ARADDR_IN & 32'hFFFF_FFFC;

    // keeps the written word so the owner mask can be compared later
    always_ff @(posedge CORE_CLK_IN) begin
        if (wr_take) begin
            en_exp_q <= S_AXI_WDATA_IN[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_owns_reset:
        assert property ($rose(RST_N_IN) |-> GPIO_OWNS_PIN_OUT == 16'h00F9)
        else $error("owner mask wrong after reset");
    // both samples of the mask must be clear, so either copy timing passes
    a_dis_oe_alt:
        assert property ($past(RST_N_IN) |-> ((GP_PIN_OE_N_OUT
            ^ $past(ALT_OE_N_IN)) & ~GPIO_OWNS_PIN_OUT
            & ~$past(GPIO_OWNS_PIN_OUT)) == 16'h0000)
        else $error("disabled pin enable not passed through");
    a_dis_out_alt:
        assert property ($past(RST_N_IN) |-> ((GP_PIN_OUT
            ^ $past(ALT_OUT_IN)) & ~GPIO_OWNS_PIN_OUT
            & ~$past(GPIO_OWNS_PIN_OUT)) == 16'h0000)
        else $error("disabled pin value not passed through");
    a_en_write_owns:
        assert property (wr_take && aw_word == 32'h01B0_0000
            && S_AXI_WSTRB_IN[1:0] == 2'h3
            |=> ##[1:2] GPIO_OWNS_PIN_OUT == en_exp_q)
        else $error("enable write not reflected on owner mask");
    a_rd_upper_zero:
        assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:16] == 16'h0)
        else $error("reserved read bits not zero");
    a_rd_enable_map:
        assert property (rd_take && ar_word == 32'h01B0_0000 |-> ##[2:3]
            S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h0
            && S_AXI_RDATA_OUT[15:0] == GPIO_OWNS_PIN_OUT)
        else $error("enable read wrong");
    a_rd_dir_map:
        assert property (rd_take && ar_word == 32'h01B0_0004 |-> ##[2:3]
            S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h0)
        else $error("direction read not answered okay");
    a_rd_unmapped:
        assert property (rd_take && ar_word == 32'h01B0_0010 |-> ##[2:3]
            S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h3
            && S_AXI_RDATA_OUT == 32'h0)
        else $error("unmapped read not refused");
    a_wr_unmapped:
        assert property (wr_take && aw_word == 32'h01B0_0010 |-> ##[2:3]
            S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'h3)
        else $error("unmapped write not refused");
endmodule : gpio_pin_enable_direction_assertions

// ---- gpio_pin_enable_direction_bench.sv ----
`timescale 1ns/10ps
module gpio_pin_enable_direction_bench;
    import gpio_cfg_pkg::*;
    localparam logic [31:0] EN_A = 32'h01B0_0000;
    localparam logic [31:0] DIR_A = 32'h01B0_0004;
    localparam logic [31:0] DO_A = 32'h01B0_0008;
    localparam logic [31:0] ST_A = 32'h01B0_000C;
    localparam logic [31:0] BAD_A = 32'h01B0_0010;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata, tmp;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] pin_in, alt_out, alt_oe_n, pin_out, pin_oe_n, owns;
    logic [15:0] en, dir, dout;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    int          err_total, compares, seed;

    gpio_pin_enable_direction dut_u (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .GP_PIN_IN(pin_in),
        .ALT_OUT_IN(alt_out), .ALT_OE_N_IN(alt_oe_n),
        .GP_PIN_OUT(pin_out), .GP_PIN_OE_N_OUT(pin_oe_n),
        .GPIO_OWNS_PIN_OUT(owns)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    // pins settle one edge after the register, so three edges is ample
    task automatic chk_pins();
        repeat (3) @(posedge clk);
        chk(34'(owns), 34'(en));
        chk(34'(pin_oe_n), 34'((en & ~dir) | (~en & alt_oe_n)));
        chk(34'(pin_out), 34'((en & dout) | (~en & alt_out)));
        rd(EN_A, {16'h0, en}, 2'h0);
        rd(DIR_A, {16'h0, dir}, 2'h0);
    endtask : chk_pins

    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    // the queues pair each answer with the oldest expectation
    always @(posedge clk) begin
        if (bvalid === 1'b1 && bready) begin
            chk(34'(bresp), 34'(bq.pop_front()));
        end
        if (rvalid === 1'b1 && rready) begin
            chk({rresp, rdata}, rq.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 23;
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        {pin_in, alt_out, alt_oe_n} = 48'h0;
        {en, dir, dout} = {16'h00F9, 16'h0000, 16'h0000};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        chk_pins();
        for (int i = 0; i < 8; i++) begin
            tmp = $random(seed);
            en = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : tmp[15:0];
            dir = (i == 0) ? 16'hFFFF : tmp[31:16];
            dout = 16'($random(seed));
            alt_out <= 16'($random(seed));
            alt_oe_n <= 16'($random(seed));
            pin_in <= 16'($random(seed));
            wr(EN_A, {tmp[31:16], en}, 2'h0);
            wr(DIR_A, {tmp[15:0], dir}, 2'h0);
            wr(DO_A, {16'h0, dout}, 2'h0);
            chk_pins();
            rd(ST_A, {16'h0, pin_in}, 2'h0);
        end
        // unmapped access must leave the configuration untouched
        wr(BAD_A, 32'h0000_0000, 2'h3);
        rd(BAD_A, 32'h0, 2'h3);
        chk_pins();
        // only byte lane 1 written: bits 15..8 change, bits 7..0 stay
        wstrb <= 4'h2;
        en = {8'hA5, en[7:0]};
        wr(EN_A, 32'h00FF_A53C, 2'h0);
        wstrb <= 4'hF;
        chk_pins();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        {en, dir, dout} = {16'h00F9, 16'h0000, 16'h0000};
        chk_pins();
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule : gpio_pin_enable_direction_bench

bind gpio_pin_enable_direction
    gpio_pin_enable_direction_assertions chk_u (.*);
